// [logic/bmsl_link_if.sv]
// Two-wire link between modulator and filtering receiver
`timescale 1ns/1ps
interface bmsl_link_if;

	logic sample_clock_in;
	logic modulator_bit_out;

	modport modulator (
		input  sample_clock_in,
		output modulator_bit_out
	);

	modport receiver (
		output sample_clock_in,
		input  modulator_bit_out
	);

endinterface : bmsl_link_if

// [logic/bmsl_modulator.sv]
// Second-order sigma-delta modulator end of the link
`timescale 1ns/1ps
module bmsl_modulator #(
	parameter int unsigned ANALOG_W = bmsl_pkg::ANALOG_W
) (
	input  wire logic                       clock,
	input  wire logic                       rst,
	bmsl_link_if.modulator                  link,
	input  wire logic signed [ANALOG_W-1:0] analog_in
);

	localparam int unsigned I1W = ANALOG_W + 4;
	localparam int unsigned I2W = ANALOG_W + 6;

	generate
		if (ANALOG_W < 4 || ANALOG_W > 24)
		begin : g_bad_width
			$error("bmsl_modulator: ANALOG_W out of range");
		end
	endgenerate

	// Sample clock arrives from the receiver: three-stage synchroniser
	logic sck_s1_q;
	logic sck_s2_q;
	logic sck_s3_q;
	logic sck_lvl_q;
	logic bit_q;
	logic signed [I1W-1:0] int1_q;
	logic signed [I2W-1:0] int2_q;

	wire sck_agree = (sck_s2_q == sck_s3_q);
	wire sck_rise  = sck_agree & sck_s3_q & ~sck_lvl_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sck_s1_q  <= 1'b0;
			sck_s2_q  <= 1'b0;
			sck_s3_q  <= 1'b0;
			sck_lvl_q <= 1'b0;
		end
		else
		begin
			sck_s1_q <= link.sample_clock_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			if (sck_agree)
				sck_lvl_q <= sck_s3_q;
		end
	end

	// Feedback is plus or minus full scale of the input code
	wire signed [I1W-1:0] fb1 = bit_q ? I1W'(2 ** (ANALOG_W - 1)) : -I1W'(2 ** (ANALOG_W - 1));
	wire signed [I1W-1:0] x1  = {{(I1W - ANALOG_W){analog_in[ANALOG_W-1]}}, analog_in};
	wire signed [I2W-1:0] fb2 = {{(I2W - I1W){fb1[I1W-1]}}, fb1};
	wire signed [I2W-1:0] i1x = {{(I2W - I1W){int1_q[I1W-1]}}, int1_q};
	// Half-gain delaying integrators keep the loop stable up to full scale
	wire signed [I1W-1:0] err1   = x1 - fb1;
	wire signed [I2W-1:0] err2   = i1x - fb2;
	wire signed [I1W-1:0] int1_d = int1_q + (err1 >>> 1);
	wire signed [I2W-1:0] int2_d = int2_q + (err2 >>> 1);
	// Density of ones tracks 0.5 plus input over 640 mV span
	wire                  bit_d  = ~int2_d[I2W-1];

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			int1_q <= '0;
			int2_q <= '0;
			bit_q  <= 1'b0;
		end
		else if (sck_rise)
		begin
			int1_q <= int1_d;
			int2_q <= int2_d;
			bit_q  <= bit_d;
		end
	end

	assign link.modulator_bit_out = bit_q;

endmodule : bmsl_modulator

// [logic/bmsl_pkg.sv]
// Shared constants for the one-bit modulator link and its sinc3 receiver
package bmsl_pkg;

	// Clock of both ends and the sample-clock limit
	localparam int unsigned CLK_PERIOD_PS     = 4000;
	localparam int unsigned SCLK_MAX_FREQ_KHZ = 16000;
	localparam int unsigned SCLK_MIN_PERIOD_PS = 1000000000 / SCLK_MAX_FREQ_KHZ;
	// Least period rounds up to whole cycles
	localparam int unsigned SCLK_PERIOD_CYC   =
		(SCLK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Analog input as signed code, full scale 320 mV
	localparam int unsigned ANALOG_W          = 16;
	localparam int unsigned FULL_SCALE_MV     = 320;
	localparam int unsigned SPEC_RANGE_MV     = 200;

	// Decimation and output word
	localparam int unsigned DECIM_RATE        = 256;
	localparam int unsigned WORD_W            = 16;
	localparam int unsigned SETTLE_WORDS      = 4;
	localparam logic [15:0] CODE_NEG_SPEC     = 16'h3000;
	localparam logic [15:0] CODE_MIDSCALE     = 16'h8000;
	localparam logic [15:0] CODE_POS_SPEC     = 16'hd000;

	// Receiver sequencing
	typedef enum logic [2:0] {
		BMSL_IDLE = 3'b001,
		BMSL_FILL = 3'b010,
		BMSL_RUN  = 3'b100
	} bmsl_state_t;

	function automatic int unsigned bmsl_clog2(input int unsigned v);
		int unsigned r;
		r = 0;
		while ((32'd1 << r) < v)
			r = r + 1;
		return r;
	endfunction : bmsl_clog2

endpackage : bmsl_pkg

// [logic/bmsl_sinc3_rx.sv]
// Receiver end: sample clock source and sinc3 decimation filter
`timescale 1ns/1ps
module bmsl_sinc3_rx #(
	parameter int unsigned SCLK_PERIOD = bmsl_pkg::SCLK_PERIOD_CYC,
	parameter int unsigned DECIM       = bmsl_pkg::DECIM_RATE,
	parameter int unsigned WORD_W      = bmsl_pkg::WORD_W
) (
	input  wire logic              clock,
	input  wire logic              rst,
	bmsl_link_if.receiver          link,
	input  wire logic              run_en,
	output logic [WORD_W-1:0]      word_out,
	output logic                   word_valid,
	output logic                   settled
);

	localparam int unsigned LOG2D = bmsl_pkg::bmsl_clog2(DECIM);
	localparam int unsigned ACC_W = 3 * LOG2D;
	localparam int unsigned HALF  = SCLK_PERIOD / 2;
	localparam int unsigned DIV_W = bmsl_pkg::bmsl_clog2(HALF) + 1;
	localparam int unsigned SET_W = 3;

	generate
		if ((SCLK_PERIOD % 2) != 0 || SCLK_PERIOD < bmsl_pkg::SCLK_PERIOD_CYC)
		begin : g_bad_period
			$error("bmsl_sinc3_rx: SCLK_PERIOD must be even and within 16 MHz");
		end
		if ((32'd1 << LOG2D) != DECIM || ACC_W < WORD_W || ACC_W > 48)
		begin : g_bad_decim
			$error("bmsl_sinc3_rx: DECIM must be a power of two wide enough for WORD_W");
		end
		if (bmsl_pkg::SETTLE_WORDS >= (1 << SET_W))
		begin : g_bad_settle
			$error("bmsl_sinc3_rx: settle count too wide");
		end
	endgenerate

	bmsl_pkg::bmsl_state_t state_q;
	bmsl_pkg::bmsl_state_t state_d;

	// Sample clock made here by dividing the own clock
	logic [DIV_W-1:0] div_q;
	logic             sck_q;

	wire running  = (state_q != bmsl_pkg::BMSL_IDLE);
	wire div_wrap = (div_q == DIV_W'(HALF - 1));
	wire sck_rise = running & div_wrap & ~sck_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			div_q <= '0;
			sck_q <= 1'b0;
		end
		else if (!running)
		begin
			div_q <= '0;
			sck_q <= 1'b0;
		end
		else
		begin
			div_q <= div_wrap ? '0 : div_q + 1'b1;
			if (div_wrap)
				sck_q <= ~sck_q;
		end
	end

	assign link.sample_clock_in = sck_q;

	// Modulator bit crosses in through three flip-flops
	logic bit_s1_q;
	logic bit_s2_q;
	logic bit_s3_q;
	logic bit_ok_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bit_s1_q <= 1'b0;
			bit_s2_q <= 1'b0;
			bit_s3_q <= 1'b0;
			bit_ok_q <= 1'b0;
		end
		else
		begin
			bit_s1_q <= link.modulator_bit_out;
			bit_s2_q <= bit_s1_q;
			bit_s3_q <= bit_s2_q;
			if (bit_s2_q == bit_s3_q)
				bit_ok_q <= bit_s3_q;
		end
	end

	// Integrators at the sample rate; bit taken at the next rising edge
	logic [ACC_W-1:0] acc1_q;
	logic [ACC_W-1:0] acc2_q;
	logic [ACC_W-1:0] acc3_q;
	logic [LOG2D-1:0] samp_cnt_q;

	wire [ACC_W-1:0] in_bit   = {{(ACC_W - 1){1'b0}}, bit_ok_q};
	wire             dec_tick = sck_rise & (samp_cnt_q == LOG2D'(DECIM - 1));

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			acc1_q     <= '0;
			acc2_q     <= '0;
			acc3_q     <= '0;
			samp_cnt_q <= '0;
		end
		else if (!running)
		begin
			acc1_q     <= '0;
			acc2_q     <= '0;
			acc3_q     <= '0;
			samp_cnt_q <= '0;
		end
		else if (sck_rise)
		begin
			acc1_q     <= acc1_q + in_bit;
			acc2_q     <= acc2_q + acc1_q;
			acc3_q     <= acc3_q + acc2_q;
			samp_cnt_q <= samp_cnt_q + 1'b1;
		end
	end

	// Differentiators once per decimated word
	logic [ACC_W-1:0] acc3_d_q;
	logic [ACC_W-1:0] diff1_q;
	logic [ACC_W-1:0] diff1_d_q;
	logic [ACC_W-1:0] diff2_q;
	logic [ACC_W-1:0] diff2_d_q;
	logic [ACC_W-1:0] diff3_q;
	logic             word_stb_q;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			acc3_d_q   <= '0;
			diff1_q    <= '0;
			diff1_d_q  <= '0;
			diff2_q    <= '0;
			diff2_d_q  <= '0;
			diff3_q    <= '0;
			word_stb_q <= 1'b0;
		end
		else
		begin
			word_stb_q <= dec_tick;
			if (!running)
			begin
				acc3_d_q  <= '0;
				diff1_q   <= '0;
				diff1_d_q <= '0;
				diff2_q   <= '0;
				diff2_d_q <= '0;
				diff3_q   <= '0;
			end
			else if (dec_tick)
			begin
				diff1_q   <= acc3_q - acc3_d_q;
				diff2_q   <= diff1_q - diff1_d_q;
				diff3_q   <= diff2_q - diff2_d_q;
				acc3_d_q  <= acc3_q;
				diff1_d_q <= diff1_q;
				diff2_d_q <= diff2_q;
			end
		end
	end

	// First words are discarded while the filter pipeline fills
	logic [SET_W-1:0] settle_q;

	wire settle_done = (settle_q == SET_W'(bmsl_pkg::SETTLE_WORDS));

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			bmsl_pkg::BMSL_IDLE:
				if (run_en)
					state_d = bmsl_pkg::BMSL_FILL;
			bmsl_pkg::BMSL_FILL:
				if (!run_en)
					state_d = bmsl_pkg::BMSL_IDLE;
				else if (settle_done)
					state_d = bmsl_pkg::BMSL_RUN;
			bmsl_pkg::BMSL_RUN:
				if (!run_en)
					state_d = bmsl_pkg::BMSL_IDLE;
			default:
				state_d = bmsl_pkg::BMSL_IDLE;
		endcase
	end

	wire in_run = (state_q == bmsl_pkg::BMSL_RUN);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_q  <= bmsl_pkg::BMSL_IDLE;
			settle_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (state_q != bmsl_pkg::BMSL_FILL)
				settle_q <= '0;
			else if (word_stb_q && !settle_done)
				settle_q <= settle_q + 1'b1;
		end
	end

	// Output word: top bits of the third difference
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			word_out   <= '0;
			word_valid <= 1'b0;
			settled    <= 1'b0;
		end
		else
		begin
			word_valid <= word_stb_q & in_run & run_en;
			settled    <= in_run & run_en;
			if (word_stb_q)
				word_out <= diff3_q[ACC_W-1 -: WORD_W];
		end
	end

endmodule : bmsl_sinc3_rx

// [testbench/bmsl_link_sva.sv]
// Checker for the modulator link and sinc3 receiver
`timescale 1ns/1ps
module bmsl_link_sva (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        sample_clock_in,
	input wire logic        modulator_bit_out,
	input wire logic        run_en,
	input wire logic [15:0] word_out,
	input wire logic        word_valid,
	input wire logic        settled
);
	localparam int GAP = 4095;
	logic [12:0] gap_q;
	logic        seen_q;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Cycles since the last word
	always_ff @(posedge clock or posedge rst)
		if (rst)
			gap_q <= 13'h0;
		else
			gap_q <= word_valid ? 13'h0 : gap_q + 13'h1;
	always_ff @(posedge clock or posedge rst)
		if (rst)
			seen_q <= 1'b0;
		else
			seen_q <= run_en & (seen_q | word_valid);
	AST_BIT_AFTER_RISE: assert property ($changed(modulator_bit_out) |-> $past(sample_clock_in, 4))
		else $error("bit changed away from a sample clock rise");
	AST_SCK_IDLE: assert property (!run_en [*3] |-> !sample_clock_in)
		else $error("sample clock runs while stopped");
	AST_SCK_HIGH: assert property (disable iff (rst || !run_en)
		$rose(sample_clock_in) |-> sample_clock_in [*8] ##1 !sample_clock_in)
		else $error("sample clock high phase wrong");
	AST_SCK_LOW: assert property (disable iff (rst || !run_en)
		$fell(sample_clock_in) |-> !sample_clock_in [*8] ##1 sample_clock_in)
		else $error("sample clock low phase wrong");
	AST_VALID_PULSE: assert property (word_valid |=> !word_valid)
		else $error("word strobe longer than one cycle");
	AST_VALID_SETTLED: assert property (word_valid |-> settled)
		else $error("word strobe before filter settled");
	AST_WORD_HOLD: assert property ($changed(word_out) && $past(settled) |-> word_valid)
		else $error("word changed without strobe");
	AST_WORD_GAP: assert property (word_valid && seen_q |-> gap_q == GAP)
		else $error("word spacing wrong");
	AST_STOP_CLEARS: assert property (!run_en |=> !settled && !word_valid)
		else $error("stop did not clear receiver");
endmodule : bmsl_link_sva

// [testbench/test_bitstream_modulator_sinc3_link.sv]
// Self-checking bench for the modulator link and sinc3 receiver
`timescale 1ns/1ps
module test_bitstream_modulator_sinc3_link;
	logic               clock = 1'b0;
	logic               rst = 1'b1;
	logic               run_en = 1'b0;
	logic signed [15:0] analog_in = 16'sh0;
	logic [15:0]        word_out;
	logic               word_valid;
	logic               settled;
	logic               sck_prev = 1'b0;
	int                 n_mismatch = 0;
	int                 tests_run = 0;
	int                 seed = 95561;
	int                 ones = 0;
	int                 bits[$];
	int                 a_cur = 0;
	int                 n_since = 6;
	bmsl_link_if link ();
	bmsl_modulator i_bmsl_modulator (.clock(clock), .rst(rst), .link(link), .analog_in(analog_in));
	bmsl_sinc3_rx i_bmsl_sinc3_rx (.clock(clock), .rst(rst), .link(link), .run_en(run_en),
		.word_out(word_out), .word_valid(word_valid), .settled(settled));
	bmsl_link_sva u_chk (.clock(clock), .rst(rst), .sample_clock_in(link.sample_clock_in),
		.modulator_bit_out(link.modulator_bit_out), .run_en(run_en), .word_out(word_out),
		.word_valid(word_valid), .settled(settled));
	always #2 clock = ~clock;
	// Ones count over the last 256 link bits
	always @(negedge clock)
	begin
		if (link.sample_clock_in === 1'b1 && sck_prev === 1'b0)
		begin
			bits.push_back(link.modulator_bit_out === 1'b1);
			ones += (link.modulator_bit_out === 1'b1);
			if (bits.size() > 256)
				ones -= bits.pop_front();
		end
		sck_prev = link.sample_clock_in;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_word();
		int n;
		n = 0;
		do
		begin
			@(negedge clock);
			n++;
		end
		while (word_valid !== 1'b1 && n < 24000);
		check(32'(n < 24000), 32'h1);
		// Model: every word from the sixth after a step lies less than 64 codes from the ideal code
		n_since++;
		if (n_since >= 6)
			check(32'(word_out > 32768 + a_cur - 64 && word_out < 32768 + a_cur + 64), 32'h1);
	endtask : wait_word
	// Ideal code is midscale plus input, density 128 plus input/256
	task automatic run_value(input int a, input int n_words);
		int e;
		int d;
		@(posedge clock);
		analog_in <= 16'(a);
		a_cur = a;
		n_since = 0;
		// Sinc3 window plus difference pipeline spans six words
		repeat (n_words)
			wait_word();
		@(negedge clock);
		e = 32768 + a;
		d = 128 + a / 256;
		check(32'(word_out > e - 64 && word_out < e + 64), 32'h1);
		check(32'(ones > d - 4 && ones < d + 4), 32'h1);
		check(32'(settled), 32'h1);
	endtask : run_value
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		#440000;
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		repeat (12)
			@(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		run_en <= 1'b1;
		repeat (100)
			@(posedge clock);
		run_en <= 1'b0;
		repeat (20)
			@(posedge clock);
		@(negedge clock);
		check(32'({settled, word_valid, link.sample_clock_in}), 32'h0);
		@(posedge clock);
		run_en <= 1'b1;
		wait_word();
		run_value(0, 0);
		run_value(20480, 6);
		run_value(-20480, 6);
		run_value($random(seed) % 20481, 6);
		// Full scale: stream nearly all ones
		@(posedge clock);
		analog_in <= 16'sh7fff;
		repeat (4800)
			@(posedge clock);
		@(negedge clock);
		check(32'(ones > 128 + 32767 / 256 - 4), 32'h1);
		print_verdict();
	end
endmodule : test_bitstream_modulator_sinc3_link
